// ==== fadc_pkg.sv ====
// Package of types and timing constants for the flash converter host port
package fadc_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned NEXT_CONV_NS = 500;
  localparam int unsigned START_TO_FETCH_NS = 400;
  localparam int unsigned START_PULSE_MIN_NS = 500;
  localparam int unsigned START_PULSE_MAX_NS = 50000;
  localparam int unsigned COUNTDOWN_NS = 1300;
  localparam int unsigned CONV_READ_NS = 2500;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W = 16;
  // Least times round up
  localparam int unsigned NEXT_CONV_CYC =
    (NEXT_CONV_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned START_TO_FETCH_CYC =
    (START_TO_FETCH_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned START_PULSE_CYC =
    (START_PULSE_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned START_PULSE_MAX_CYC =
    (START_PULSE_MAX_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned COUNTDOWN_CYC =
    (COUNTDOWN_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned CONV_READ_CYC =
    (CONV_READ_NS * (CLK_HZ / 1000000) + 999) / 1000;

  typedef enum logic {
    FADC_MODE_READ_ONLY,
    FADC_MODE_WRITE_READ
  } fadc_mode_type;

  typedef struct packed {
    logic [DATA_W-1:0] code;
    logic overrange;
  } fadc_result_type;

  typedef struct packed {
    logic select_n;
    logic fetch_n;
    logic start_n_out;
    logic start_n_oe;
  } fadc_strobe_type;
endpackage : fadc_pkg

// ==== fadc_timer.sv ====
// Down-counting cycle timer with a one-cycle done pulse
`timescale 1ns/1ps
`default_nettype none
module fadc_timer
  import fadc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Control
  input wire logic load,
  input wire logic [CNT_W-1:0] count,
  // Status
  output logic done,
  output logic busy
);
  logic [CNT_W-1:0] cnt_ff;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= '0;
      done <= 1'b0;
    end else if (load) begin
      cnt_ff <= count;
      done <= 1'b0;
    end else begin
      done <= (cnt_ff == 16'h0001);
      if (cnt_ff != '0) begin
        cnt_ff <= cnt_ff - 16'h0001;
      end
    end
  end

  assign busy = (cnt_ff != '0);
endmodule : fadc_timer
`default_nettype wire

// ==== fadc_host_ctrl.sv ====
// Host controller driving the flash converter's parallel port pins
`timescale 1ns/1ps
`default_nettype none
module fadc_host_ctrl
  import fadc_pkg::*;
#(
  parameter int unsigned WRITE_PULSE_CYC = START_PULSE_CYC,
  parameter int unsigned FETCH_WAIT_CYC = START_TO_FETCH_CYC,
  parameter int unsigned CONV_TIMEOUT_CYC = CONV_READ_CYC + 2
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // User request
  input wire logic req,
  input wire logic req_write_read,
  input wire logic req_early_fetch,
  output logic req_ready_ff,
  // User result
  output logic result_valid_ff,
  output fadc_result_type result_ff,
  output logic result_timeout_ff,
  // Converter pins
  output logic select_n_ff,
  output logic fetch_n_ff,
  output logic mode_ff,
  output logic start_n_out_ff,
  output logic start_n_oe_ff,
  input wire logic ready_n_in,
  input wire logic done_n,
  input wire logic overrange_flag_n,
  input wire logic [DATA_W-1:0] result_bits
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_WPULSE, ST_WGAP, ST_WAIT_DONE,
    ST_FETCH, ST_RWAIT, ST_CAPTURE, ST_RELEASE, ST_RECOVER
  } fadc_state_type;

  fadc_state_type state_ff;
  logic wr_mode_ff;
  logic early_ff;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_count;
  logic tmr_done;
  logic tmr_busy;
  logic [CNT_W-1:0] wait_ff;

  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    cyc = n[CNT_W-1:0];
  endfunction : cyc

  fadc_timer u_timer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done),
    .busy(tmr_busy)
  );

  // Timer loads on entering timed states
  always_comb begin
    tmr_load = 1'b0;
    tmr_count = '0;
    case (state_ff)
      ST_SETUP: begin
        tmr_load = 1'b1;
        tmr_count = wr_mode_ff ? cyc(WRITE_PULSE_CYC) : cyc(1);
      end
      ST_WPULSE: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_count = cyc(FETCH_WAIT_CYC);
        end
      end
      ST_RELEASE: begin
        tmr_load = 1'b1;
        tmr_count = cyc(NEXT_CONV_CYC);
      end
      default: begin
        tmr_load = 1'b0;
      end
    endcase
  end

  // Sequencer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_RELEASE;
      wr_mode_ff <= 1'b0;
      early_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (req) begin
            wr_mode_ff <= req_write_read;
            early_ff <= req_early_fetch;
            state_ff <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          state_ff <= wr_mode_ff ? ST_WPULSE : ST_FETCH;
        end
        ST_WPULSE: begin
          if (tmr_done) begin
            state_ff <= ST_WGAP;
          end
        end
        ST_WGAP: begin
          if (tmr_done) begin
            state_ff <= early_ff ? ST_FETCH : ST_WAIT_DONE;
          end
        end
        ST_WAIT_DONE: begin
          if (!done_n || wait_ff == cyc(CONV_TIMEOUT_CYC)) begin
            state_ff <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          state_ff <= ST_RWAIT;
        end
        ST_RWAIT: begin
          if ((!done_n && (wr_mode_ff || ready_n_in)) ||
              wait_ff == cyc(CONV_TIMEOUT_CYC)) begin
            state_ff <= ST_CAPTURE;
          end
        end
        ST_CAPTURE: begin
          state_ff <= ST_RELEASE;
        end
        ST_RELEASE: begin
          state_ff <= ST_RECOVER;
        end
        ST_RECOVER: begin
          if (!tmr_busy && !tmr_load) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Wait counter for completion timeout
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_ff <= '0;
    end else if (state_ff == ST_WAIT_DONE || state_ff == ST_RWAIT) begin
      wait_ff <= wait_ff + 16'h0001;
    end else begin
      wait_ff <= '0;
    end
  end

  // Pin drive
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      select_n_ff <= 1'b1;
      fetch_n_ff <= 1'b1;
      mode_ff <= 1'b0;
      start_n_out_ff <= 1'b1;
      start_n_oe_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (req) begin
            mode_ff <= req_write_read;
            start_n_oe_ff <= req_write_read;
            start_n_out_ff <= 1'b1;
          end
        end
        ST_SETUP: begin
          select_n_ff <= 1'b0;
          if (wr_mode_ff) begin
            start_n_out_ff <= 1'b0;
          end
        end
        ST_WPULSE: begin
          if (tmr_done) begin
            start_n_out_ff <= 1'b1;
          end
        end
        ST_FETCH: begin
          fetch_n_ff <= 1'b0;
        end
        ST_CAPTURE: begin
          fetch_n_ff <= 1'b1;
        end
        ST_RELEASE: begin
          select_n_ff <= 1'b1;
          start_n_oe_ff <= 1'b0;
        end
        default: begin
          select_n_ff <= select_n_ff;
        end
      endcase
    end
  end

  // Result capture; LSB on line one
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_ff <= '0;
      result_valid_ff <= 1'b0;
      result_timeout_ff <= 1'b0;
    end else begin
      result_valid_ff <= 1'b0;
      if (state_ff == ST_CAPTURE) begin
        result_ff.code <= result_bits;
        result_ff.overrange <= ~overrange_flag_n;
        result_valid_ff <= 1'b1;
        result_timeout_ff <= done_n || (!wr_mode_ff && !ready_n_in);
      end
    end
  end

  // Request readiness
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_ready_ff <= 1'b0;
    end else begin
      req_ready_ff <= (state_ff == ST_IDLE) && !req;
    end
  end
endmodule : fadc_host_ctrl
`default_nettype wire

// ==== fadc_host_ctrl_checker.sv ====
// Assertions on the host controller pins and results
`timescale 1ns/1ps
`default_nettype none
module fadc_host_ctrl_checker
  import fadc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk, sys_rst,
  // User side
  input wire logic req, req_write_read, req_early_fetch, req_ready_ff,
  input wire logic result_valid_ff, result_timeout_ff,
  input wire fadc_result_type result_ff,
  // Converter pins
  input wire logic select_n_ff, fetch_n_ff, mode_ff,
  input wire logic start_n_out_ff, start_n_oe_ff,
  input wire logic ready_n_in, done_n, overrange_flag_n,
  input wire logic [DATA_W-1:0] result_bits
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_fetch_needs_select: assert property (!fetch_n_ff |-> !select_n_ff)
    else $error("Read strobe without select");
  a_write_needs_select: assert property (start_n_oe_ff && !start_n_out_ff
    |-> !select_n_ff) else $error("Write strobe without select");
  a_write_mode_high: assert property (start_n_oe_ff && !select_n_ff
    |-> mode_ff) else $error("Mode low in write-read");
  a_read_mode_low: assert property (!start_n_oe_ff && !select_n_ff
    |-> !mode_ff) else $error("Mode high in read-only");
  a_pulse_min_width: assert property ($fell(start_n_out_ff)
    |-> (!start_n_out_ff)[*8] ##1 !start_n_out_ff ##1 !start_n_out_ff)
    else $error("Write pulse too short");
  a_next_conv_gap: assert property ($rose(select_n_ff)
    |-> select_n_ff[*8] ##1 select_n_ff ##1 select_n_ff)
    else $error("Next conversion too soon");
  a_fetch_after_write: assert property ($rose(start_n_out_ff)
    |-> fetch_n_ff[*8]) else $error("Read strobe too soon after write");
  a_capture_data: assert property (result_valid_ff
    |-> result_ff.code == $past(result_bits)) else $error("Bad capture");
  a_fetch_waits_done: assert property ($rose(fetch_n_ff)
    |-> !$past(done_n)) else $error("Read strobe ended early");
endmodule : fadc_host_ctrl_checker
`default_nettype wire

// ==== fadc_dev_model.sv ====
// Behavioural model of the flash converter on the host port
`timescale 1ns/1ps
`default_nettype none
module fadc_dev_model
  import fadc_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Host pins
  input wire logic select_n_ff, fetch_n_ff, mode_ff,
  input wire logic start_n_out_ff, start_n_oe_ff,
  // Conversion setup
  input wire logic [DATA_W-1:0] dev_code,
  input wire logic dev_over,
  input wire logic [7:0] dev_dly,
  // Device outputs
  output logic ready_n_in, done_n, overrange_flag_n,
  output logic [DATA_W-1:0] result_bits
);
  logic busy_ff = 1'b0, done_ff = 1'b0, wr_q = 1'b1, fet_q = 1'b1;
  logic [7:0] cnt_ff = 8'h00;
  logic [DATA_W-1:0] last_ff = 8'h00;
  wire wr_n = start_n_oe_ff ? start_n_out_ff : 1'b1;
  always_ff @(posedge core_clk) begin
    wr_q <= wr_n;
    fet_q <= fetch_n_ff;
    last_ff <= result_bits;
    if (select_n_ff) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (mode_ff && wr_q && !wr_n) begin
      busy_ff <= 1'b1;
      cnt_ff <= dev_dly;
    end else if (!mode_ff && fet_q && !fetch_n_ff) begin
      busy_ff <= 1'b1;
      cnt_ff <= dev_dly;
    end else if (busy_ff && fet_q && !fetch_n_ff) begin
      cnt_ff <= 8'h05;
    end else if (busy_ff) begin
      cnt_ff <= cnt_ff - 8'h01;
      if (cnt_ff == 8'h00) begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
      end
    end else if (fetch_n_ff && !fet_q) begin
      done_ff <= 1'b0;
    end
  end
  assign done_n = !done_ff;
  assign ready_n_in = (!mode_ff && !select_n_ff && !done_ff) ? 1'b0 : 1'b1;
  assign overrange_flag_n = (done_ff && dev_over) ? 1'b0 : 1'b1;
  assign result_bits = (!select_n_ff && !fetch_n_ff && (mode_ff || done_ff))
    ? dev_code : ~last_ff;
endmodule : fadc_dev_model
`default_nettype wire

// ==== tb_fadc_host_ctrl.sv ====
// Self-checking testbench of the converter host controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  fail_count++; $display("Error %0t: mismatch line %0d", $time, `__LINE__); \
  end end
`define WAITC(c) begin n = 0; do begin @(negedge core_clk); n++; \
  if (n > 400) begin fail_count++; give_verdict(); end \
  end while ((c) !== 1'b1); end
module tb_fadc_host_ctrl
  import fadc_pkg::*;
;
  logic core_clk = 0, sys_rst = 1, req = 0, req_write_read = 0;
  logic req_early_fetch = 0, req_ready_ff, result_valid_ff;
  logic result_timeout_ff, select_n_ff, fetch_n_ff, mode_ff;
  logic start_n_out_ff, start_n_oe_ff, ready_n_in, done_n;
  logic overrange_flag_n, dev_over = 0;
  logic [DATA_W-1:0] result_bits, dev_code = 0;
  logic [7:0] dev_dly = 8'h1a;
  fadc_result_type result_ff;
  int fail_count = 0, samples_checked = 0, n, k;
  fadc_host_ctrl dut (.core_clk, .sys_rst, .req, .req_write_read,
    .req_early_fetch, .req_ready_ff, .result_valid_ff, .result_ff,
    .result_timeout_ff, .select_n_ff, .fetch_n_ff, .mode_ff,
    .start_n_out_ff, .start_n_oe_ff, .ready_n_in, .done_n,
    .overrange_flag_n, .result_bits);
  fadc_dev_model dev (.core_clk, .select_n_ff, .fetch_n_ff, .mode_ff,
    .start_n_out_ff, .start_n_oe_ff, .dev_code, .dev_over, .dev_dly,
    .ready_n_in, .done_n, .overrange_flag_n, .result_bits);
  initial forever #25 core_clk = ~core_clk;
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic conv(input logic wr, ef, ov, input logic [7:0] c, dl);
    @(posedge core_clk);
    req_write_read <= wr;
    req_early_fetch <= ef;
    dev_over <= ov;
    dev_code <= c;
    dev_dly <= dl;
    `WAITC(req_ready_ff)
    @(posedge core_clk) req <= 1'b1;
    @(posedge core_clk) req <= 1'b0;
    `WAITC(!select_n_ff)
    `CHK(mode_ff, wr)
    `WAITC(result_valid_ff)
    `CHK(result_ff.code, c)
    `CHK(result_ff.overrange, ov)
    `CHK(result_timeout_ff, 1'b0)
  endtask : conv
  task automatic t_read_only;
    conv(1'b0, 1'b0, 1'b0, 8'h00, 8'h2d);
    conv(1'b0, 1'b0, 1'b1, 8'hff, 8'h28);
    conv(1'b0, 1'b0, 1'b0, 8'h01, 8'h02);
    conv(1'b0, 1'b0, 1'b0, 8'h80, 8'h10);
    $display("Read-only test ended");
  endtask : t_read_only
  task automatic t_write_read;
    conv(1'b1, 1'b0, 1'b0, 8'h5a, 8'h1a);
    conv(1'b1, 1'b1, 1'b1, 8'ha5, 8'h30);
    `CHK(n < 40, 1'b1)
    $display("Write-read test ended");
  endtask : t_write_read
  task automatic t_back_to_back;
    @(posedge core_clk);
    req_write_read <= 1'b0;
    req <= 1'b1;
    `WAITC(!select_n_ff)
    `CHK(req_ready_ff, 1'b0)
    `WAITC(select_n_ff)
    for (k = 0; select_n_ff === 1'b1 && k < 60; k++) @(negedge core_clk);
    `CHK(k >= NEXT_CONV_CYC, 1'b1)
    `WAITC(result_valid_ff)
    `CHK(result_ff.code, 8'ha5)
    @(posedge core_clk) req <= 1'b0;
    $display("Back-to-back test ended");
  endtask : t_back_to_back
  task automatic t_reset_mid;
    @(posedge core_clk);
    req_write_read <= 1'b1;
    req <= 1'b1;
    `WAITC(!select_n_ff)
    @(posedge core_clk);
    sys_rst <= 1'b1;
    req <= 1'b0;
    @(negedge core_clk);
    `CHK(select_n_ff, 1'b1)
    `CHK(mode_ff, 1'b0)
    `CHK(start_n_oe_ff, 1'b0)
    @(posedge core_clk) sys_rst <= 1'b0;
    conv(1'b0, 1'b0, 1'b0, 8'h3c, 8'h28);
    $display("Mid-run reset test ended");
  endtask : t_reset_mid
  initial begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_read_only();
    t_write_read();
    t_back_to_back();
    t_reset_mid();
    give_verdict();
  end
endmodule : tb_fadc_host_ctrl
bind fadc_host_ctrl fadc_host_ctrl_checker u_chk (.core_clk, .sys_rst, .req,
  .req_write_read, .req_early_fetch, .req_ready_ff, .result_valid_ff,
  .result_timeout_ff, .result_ff, .select_n_ff, .fetch_n_ff, .mode_ff,
  .start_n_out_ff, .start_n_oe_ff, .ready_n_in, .done_n,
  .overrange_flag_n, .result_bits);
`default_nettype wire
